// ### nested_irq_controller.sv
`timescale 1ns/10ps
// Notes on behaviour
// - four configurable priority levels, 0 most urgent, 3 least urgent.
// - every configurable priority resets to level 0.
// - NMI and hard fault rank above level 0; reset outranks all.
// - svc 11, pendable service 14, timer 15, lines 0..31 at 16..47.
// - line n uses number 16+n, vector 0x40+4n; line 0 brown-out, 1 watchdog.
// - lines 2 and 3 carry the two dedicated external pin interrupts.
// - line 4 ports 0 and 1; line 5 ports 2..4 without dedicated pins.
// - vector word 0 holds stack pointer; word k serves exception k.
// - write-1 set/clear enable; zeros ignored; both read enable state.
// - a disabled request still becomes pending but never activates.
// - disabling an active line keeps it active until return or reset.
// - write-1 set/clear pending; both read the pending state.
// - clearing pending leaves active status untouched.
// - 8-bit priority field, four fields per 32-bit register.
// - enable, pending and priority registers are memory mapped.
module nested_irq_controller #(
  parameter int NUM_IRQ = 32
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // synchronous reset, low
  input wire logic [31:0] periphIrq, // on-chip lines 6 and up
  input wire logic brownout_irq, // line 0
  input wire logic watchdog_irq, // line 1
  input wire logic ext_pin_irq_a, // dedicated pin a, async
  input wire logic ext_pin_irq_b, // dedicated pin b, async
  input wire logic [15:0] portLowPins, // ports 0 and 1 pin events, async
  input wire logic [23:0] portHighPins, // ports 2..4, dedicated excluded, async
  input wire logic nmiReq, // non-maskable request
  input wire logic hardFaultReq, // hard fault request
  input wire logic system_timer_exc, // timer tick request
  input wire logic supervisor_call_exc, // svc instruction pulse
  input wire logic excAck, // core takes offered exception
  input wire logic excReturn, // core returns from excReturnNum
  input wire logic [5:0] excReturnNum, // exception being returned
  output irq_ctrl_pkg::exc_req_t excReq, // offered exception
  output logic wakeReq, // power-down wake request
  output logic irqOut, // unmasked event interrupt
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  if (NUM_IRQ != 32) begin : gBadCount
    $error("NUM_IRQ must be 32");
  end

  localparam int EXT_W = 42;

  typedef struct packed {
    logic [31:0] enable;
    logic [31:0] pending;
    logic [31:0] active;
    logic [31:0][1:0] prio;
    logic [2:0] sysPend;
    logic [2:0] sysActive;
    logic [2:0][1:0] sysPrio;
    logic nmiActive;
    logic faultActive;
    logic [31:0] lineLast;
    logic [EXT_W-1:0] sync1;
    logic [EXT_W-1:0] sync2;
    logic [irq_ctrl_pkg::EVT_W-1:0] evtStatus;
    logic [irq_ctrl_pkg::EVT_W-1:0] evtMask;
    irq_ctrl_pkg::exc_req_t offer;
    logic wake;
    logic awHeld;
    logic wHeld;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } state_t;

  state_t st;
  state_t next_st;
  logic [31:0] lines;
  logic [31:0] linesRise;
  logic [EXT_W-1:0] extRaw;

  // async pins gathered for the synchroniser
  assign extRaw = {portHighPins, portLowPins, ext_pin_irq_b, ext_pin_irq_a};

  // interrupt line map after synchronising
  always_comb begin
    lines = periphIrq;
    lines[0] = brownout_irq;
    lines[1] = watchdog_irq;
    lines[2] = st.sync2[0];
    lines[3] = st.sync2[1];
    lines[4] = |st.sync2[17:2];
    lines[5] = |st.sync2[41:18];
  end

  assign linesRise = lines & ~st.lineLast;

  // registered outputs
  assign excReq = st.offer;
  assign wakeReq = st.wake;
  assign irqOut = |(st.evtStatus & st.evtMask);
  assign s_axi_awready = ~st.awHeld & ~st.bValid;
  assign s_axi_wready = ~st.wHeld & ~st.bValid;
  assign s_axi_bvalid = st.bValid;
  assign s_axi_bresp = st.bResp;
  assign s_axi_arready = ~st.rValid;
  assign s_axi_rvalid = st.rValid;
  assign s_axi_rdata = st.rData;
  assign s_axi_rresp = st.rResp;

  // next-state logic
  always_comb begin
    logic [2:0] bestUrg;
    logic [5:0] bestNum;
    logic [2:0] runUrg;
    logic [2:0] urg;
    logic [31:0] wmask;
    logic [31:0] rd;
    logic rdOk;
    logic wrOk;
    logic [11:0] wa;
    logic doWrite;
    logic [irq_ctrl_pkg::EVT_W-1:0] evtSet;
    logic [4:0] idx;
    bestUrg = irq_ctrl_pkg::URG_IDLE;
    bestNum = irq_ctrl_pkg::EXC_NONE;
    runUrg = irq_ctrl_pkg::URG_IDLE;
    urg = irq_ctrl_pkg::URG_IDLE;
    wmask = 32'h0;
    rd = 32'h0;
    rdOk = 1'b1;
    wrOk = 1'b1;
    wa = 12'h0;
    doWrite = 1'b0;
    evtSet = '0;
    idx = 5'h0;
    next_st = st;
    next_st.sync1 = extRaw;
    next_st.sync2 = st.sync1;
    next_st.lineLast = lines;

    // new requests pend whether enabled or not
    next_st.pending = st.pending | linesRise;
    if (system_timer_exc) begin
      next_st.sysPend[irq_ctrl_pkg::SYS_BIT_TIMER] = 1'b1;
    end
    if (supervisor_call_exc) begin
      next_st.sysPend[irq_ctrl_pkg::SYS_BIT_SVC] = 1'b1;
    end

    // urgency of what is already running
    if (st.nmiActive) begin
      runUrg = irq_ctrl_pkg::URG_NMI;
    end else if (st.faultActive) begin
      runUrg = irq_ctrl_pkg::URG_HARD_FAULT;
    end else begin
      for (int i = 0; i < 3; i++) begin
        urg = irq_ctrl_pkg::URG_CFG_BASE + {1'b0, st.sysPrio[i]};
        if (st.sysActive[i] && urg < runUrg) runUrg = urg;
      end
      for (int i = 0; i < 32; i++) begin
        urg = irq_ctrl_pkg::URG_CFG_BASE + {1'b0, st.prio[i]};
        if (st.active[i] && urg < runUrg) runUrg = urg;
      end
    end

    // arbitration, strict less-than keeps lowest number on ties
    if (nmiReq && !st.nmiActive) begin
      bestUrg = irq_ctrl_pkg::URG_NMI;
      bestNum = irq_ctrl_pkg::EXC_NMI;
    end else if (hardFaultReq && !st.faultActive && !st.nmiActive) begin
      bestUrg = irq_ctrl_pkg::URG_HARD_FAULT;
      bestNum = irq_ctrl_pkg::EXC_HARD_FAULT;
    end else begin
      urg = irq_ctrl_pkg::URG_CFG_BASE + {1'b0, st.sysPrio[irq_ctrl_pkg::SYS_BIT_SVC]};
      if (st.sysPend[irq_ctrl_pkg::SYS_BIT_SVC] && urg < bestUrg) begin
        bestUrg = urg;
        bestNum = irq_ctrl_pkg::EXC_SUPERVISOR_CALL;
      end
      urg = irq_ctrl_pkg::URG_CFG_BASE + {1'b0, st.sysPrio[irq_ctrl_pkg::SYS_BIT_SERVICE]};
      if (st.sysPend[irq_ctrl_pkg::SYS_BIT_SERVICE] && urg < bestUrg) begin
        bestUrg = urg;
        bestNum = irq_ctrl_pkg::EXC_PENDABLE_SERVICE;
      end
      urg = irq_ctrl_pkg::URG_CFG_BASE + {1'b0, st.sysPrio[irq_ctrl_pkg::SYS_BIT_TIMER]};
      if (st.sysPend[irq_ctrl_pkg::SYS_BIT_TIMER] && urg < bestUrg) begin
        bestUrg = urg;
        bestNum = irq_ctrl_pkg::EXC_SYSTEM_TIMER;
      end
      for (int i = 0; i < 32; i++) begin
        urg = irq_ctrl_pkg::URG_CFG_BASE + {1'b0, st.prio[i]};
        if (st.pending[i] && st.enable[i] && !st.active[i] && urg < bestUrg) begin
          bestUrg = urg;
          bestNum = irq_ctrl_pkg::EXC_IRQ_BASE + 6'(i);
        end
      end
    end

    // offer only what preempts the running level
    next_st.offer.valid = (bestUrg < runUrg);
    next_st.offer.number = (bestUrg < runUrg) ? bestNum : irq_ctrl_pkg::EXC_NONE;
    next_st.offer.vector = (bestUrg < runUrg) ? {bestNum, 2'b00} : irq_ctrl_pkg::VEC_STACK_INIT;
    next_st.wake = |(st.pending & st.enable);

    // core takes the offer: pending moves to active
    if (excAck && st.offer.valid) begin
      evtSet[irq_ctrl_pkg::EVT_BIT_TAKE] = 1'b1;
      case (st.offer.number)
        irq_ctrl_pkg::EXC_NMI: next_st.nmiActive = 1'b1;
        irq_ctrl_pkg::EXC_HARD_FAULT: next_st.faultActive = 1'b1;
        irq_ctrl_pkg::EXC_SUPERVISOR_CALL: begin
          next_st.sysPend[irq_ctrl_pkg::SYS_BIT_SVC] = supervisor_call_exc; // new pulse wins
          next_st.sysActive[irq_ctrl_pkg::SYS_BIT_SVC] = 1'b1;
        end
        irq_ctrl_pkg::EXC_PENDABLE_SERVICE: begin
          next_st.sysPend[irq_ctrl_pkg::SYS_BIT_SERVICE] = 1'b0;
          next_st.sysActive[irq_ctrl_pkg::SYS_BIT_SERVICE] = 1'b1;
        end
        irq_ctrl_pkg::EXC_SYSTEM_TIMER: begin
          next_st.sysPend[irq_ctrl_pkg::SYS_BIT_TIMER] = system_timer_exc; // new tick wins
          next_st.sysActive[irq_ctrl_pkg::SYS_BIT_TIMER] = 1'b1;
        end
        default: begin
          if (st.offer.number >= irq_ctrl_pkg::EXC_IRQ_BASE) begin
            idx = 5'(st.offer.number - irq_ctrl_pkg::EXC_IRQ_BASE);
            next_st.pending[idx] = linesRise[idx];
            next_st.active[idx] = 1'b1;
          end
        end
      endcase
      next_st.offer.valid = 1'b0;
    end

    // exception return is the only clear of active besides reset
    if (excReturn) begin
      evtSet[irq_ctrl_pkg::EVT_BIT_RETURN] = 1'b1;
      case (excReturnNum)
        irq_ctrl_pkg::EXC_NMI: next_st.nmiActive = 1'b0;
        irq_ctrl_pkg::EXC_HARD_FAULT: next_st.faultActive = 1'b0;
        irq_ctrl_pkg::EXC_SUPERVISOR_CALL: next_st.sysActive[irq_ctrl_pkg::SYS_BIT_SVC] = 1'b0;
        irq_ctrl_pkg::EXC_PENDABLE_SERVICE: next_st.sysActive[irq_ctrl_pkg::SYS_BIT_SERVICE] = 1'b0;
        irq_ctrl_pkg::EXC_SYSTEM_TIMER: next_st.sysActive[irq_ctrl_pkg::SYS_BIT_TIMER] = 1'b0;
        default: begin
          if (excReturnNum >= irq_ctrl_pkg::EXC_IRQ_BASE) begin
            idx = 5'(excReturnNum - irq_ctrl_pkg::EXC_IRQ_BASE);
            next_st.active[idx] = 1'b0;
          end
        end
      endcase
    end
    if (st.wake && !(|st.evtStatus)) evtSet[irq_ctrl_pkg::EVT_BIT_WAKE] = 1'b1;

    // write channel capture in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    doWrite = st.awHeld && st.wHeld;
    wa = {st.awAddr[11:2], 2'b00};
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{st.wStrb[b]}};
    end
    if (doWrite) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bValid = 1'b1;
      case (wa)
        irq_ctrl_pkg::OFS_SET_ENABLE: next_st.enable = st.enable | (st.wData & wmask);
        irq_ctrl_pkg::OFS_CLR_ENABLE: next_st.enable = st.enable & ~(st.wData & wmask);
        irq_ctrl_pkg::OFS_SET_PEND: next_st.pending = next_st.pending | (st.wData & wmask);
        // set wins over clear for a same-cycle rising edge; active untouched
        irq_ctrl_pkg::OFS_CLR_PEND: next_st.pending = next_st.pending & ~(st.wData & wmask & ~linesRise);
        irq_ctrl_pkg::OFS_EVT_MASK: next_st.evtMask = st.wData[irq_ctrl_pkg::EVT_W-1:0];
        irq_ctrl_pkg::OFS_SYS_PEND: begin
          if (st.wData[irq_ctrl_pkg::SYS_BIT_SERVICE]) next_st.sysPend[irq_ctrl_pkg::SYS_BIT_SERVICE] = 1'b1;
        end
        irq_ctrl_pkg::OFS_SYS_PRIO: begin
          for (int i = 0; i < 3; i++) begin
            if (st.wStrb[i]) next_st.sysPrio[i] = st.wData[i*8 + irq_ctrl_pkg::PRIO_LSB +: 2];
          end
        end
        default: begin
          if (wa >= irq_ctrl_pkg::OFS_PRIO_BASE && wa <= irq_ctrl_pkg::OFS_PRIO_LAST) begin
            for (int b = 0; b < 4; b++) begin
              if (st.wStrb[b]) begin
                next_st.prio[{wa[4:2], 2'(b)}] = st.wData[b*8 + irq_ctrl_pkg::PRIO_LSB +: 2];
              end
            end
          end else if (wa != irq_ctrl_pkg::OFS_ACTIVE && wa != irq_ctrl_pkg::OFS_EVT_STATUS) begin
            wrOk = 1'b0;
          end
        end
      endcase
      next_st.bResp = wrOk ? 2'b00 : 2'b10;
    end
    if (st.bValid && s_axi_bready) next_st.bValid = 1'b0;

    // read channel, one word per request
    case ({s_axi_araddr[11:2], 2'b00})
      irq_ctrl_pkg::OFS_SET_ENABLE, irq_ctrl_pkg::OFS_CLR_ENABLE: rd = st.enable;
      irq_ctrl_pkg::OFS_SET_PEND, irq_ctrl_pkg::OFS_CLR_PEND: rd = st.pending;
      irq_ctrl_pkg::OFS_ACTIVE: rd = st.active;
      irq_ctrl_pkg::OFS_EVT_STATUS: rd = 32'(st.evtStatus);
      irq_ctrl_pkg::OFS_EVT_MASK: rd = 32'(st.evtMask);
      irq_ctrl_pkg::OFS_SYS_PEND: rd = 32'(st.sysPend);
      irq_ctrl_pkg::OFS_SYS_PRIO: begin
        for (int i = 0; i < 3; i++) rd[i*8 + irq_ctrl_pkg::PRIO_LSB +: 2] = st.sysPrio[i];
      end
      default: begin
        if (s_axi_araddr >= irq_ctrl_pkg::OFS_PRIO_BASE && s_axi_araddr <= irq_ctrl_pkg::OFS_PRIO_LAST + 12'h3) begin
          for (int b = 0; b < 4; b++) begin
            rd[b*8 + irq_ctrl_pkg::PRIO_LSB +: 2] = st.prio[{s_axi_araddr[4:2], 2'(b)}];
          end
        end else begin
          rdOk = 1'b0;
        end
      end
    endcase
    // event status: set wins over read clear
    next_st.evtStatus = st.evtStatus | evtSet;
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rValid = 1'b1;
      next_st.rData = rd;
      next_st.rResp = rdOk ? 2'b00 : 2'b10;
      if ({s_axi_araddr[11:2], 2'b00} == irq_ctrl_pkg::OFS_EVT_STATUS) next_st.evtStatus = evtSet;
    end
    if (st.rValid && s_axi_rready) next_st.rValid = 1'b0;
  end

  // state register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.prio <= {32{irq_ctrl_pkg::PRIO_RESET}};
      st.sysPrio <= {3{irq_ctrl_pkg::PRIO_RESET}};
    end else begin
      st <= next_st;
    end
  end

endmodule : nested_irq_controller

// ### irq_ctrl_pkg.sv
package irq_ctrl_pkg;

  // register byte offsets inside the controller window
  localparam logic [11:0] OFS_SET_ENABLE = 12'h100;
  localparam logic [11:0] OFS_CLR_ENABLE = 12'h180;
  localparam logic [11:0] OFS_SET_PEND = 12'h200;
  localparam logic [11:0] OFS_CLR_PEND = 12'h280;
  localparam logic [11:0] OFS_ACTIVE = 12'h300;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h400;
  localparam logic [11:0] OFS_PRIO_LAST = 12'h41C;
  localparam logic [11:0] OFS_EVT_STATUS = 12'h500;
  localparam logic [11:0] OFS_EVT_MASK = 12'h504;
  localparam logic [11:0] OFS_SYS_PEND = 12'h508;
  localparam logic [11:0] OFS_SYS_PRIO = 12'h50C;

  // priority field layout: 8-bit field, only top two bits implemented
  localparam int PRIO_FIELD_W = 8;
  localparam int PRIO_MSB = 7;
  localparam int PRIO_LSB = 6;
  localparam logic [1:0] PRIO_RESET = 2'h0;

  // exception numbers
  localparam logic [5:0] EXC_NONE = 6'h00;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD_FAULT = 6'h03;
  localparam logic [5:0] EXC_SUPERVISOR_CALL = 6'h0B;
  localparam logic [5:0] EXC_PENDABLE_SERVICE = 6'h0E;
  localparam logic [5:0] EXC_SYSTEM_TIMER = 6'h0F;
  localparam logic [5:0] EXC_IRQ_BASE = 6'h10;

  // vector table layout
  localparam logic [7:0] VEC_STACK_INIT = 8'h00;
  localparam logic [7:0] VEC_IRQ_BASE = 8'h40;

  // system pend register bit positions
  localparam int SYS_BIT_SVC = 0;
  localparam int SYS_BIT_SERVICE = 1;
  localparam int SYS_BIT_TIMER = 2;

  // event status bit positions
  localparam int EVT_BIT_TAKE = 0;
  localparam int EVT_BIT_RETURN = 1;
  localparam int EVT_BIT_WAKE = 2;
  localparam int EVT_W = 3;

  // extended urgency: 0..2 fixed, 3..6 configurable levels 0..3
  localparam logic [2:0] URG_NMI = 3'h1;
  localparam logic [2:0] URG_HARD_FAULT = 3'h2;
  localparam logic [2:0] URG_CFG_BASE = 3'h3;
  localparam logic [2:0] URG_IDLE = 3'h7;

  typedef enum {BUS_IDLE, BUS_WRESP, BUS_RRESP} bus_state_t;

  // exception offered to the core
  typedef struct packed {
    logic valid;
    logic [5:0] number;
    logic [7:0] vector;
  } exc_req_t;

endpackage : irq_ctrl_pkg

// ### irq_ctrl_checker.sv
`timescale 1ns/10ps
module irq_ctrl_checker (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset
  input wire logic nmiReq, // nmi level
  input wire logic excAck, // core take
  input irq_ctrl_pkg::exc_req_t excReq, // offer
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic [1:0] s_axi_bresp, // b code
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid // r valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // bus and core steps
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence nmiOffer;
    excReq.valid && excReq.number == irq_ctrl_pkg::EXC_NMI;
  endsequence
  // register bus answers
  chk_write_answer: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (rdTaken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write code");
  // exception offers
  chk_vector_word: assert property (excReq.valid |-> excReq.vector == {excReq.number, 2'h0})
    else $error("vector not four times number");
  chk_number_map: assert property (excReq.valid |-> excReq.number inside {6'h02, 6'h03, 6'h0B, 6'h0E, 6'h0F, [6'h10:6'h2F]})
    else $error("reserved number offered");
  chk_nmi_offer: assert property ($rose(nmiReq) |-> ##[1:4] nmiOffer)
    else $error("nmi not offered");
  chk_offer_stands: assert property (excReq.valid && !excAck |=> excReq.valid)
    else $error("offer dropped");
  chk_no_reoffer: assert property (excAck && excReq.valid |->
    ##2 !(excReq.valid && excReq.number == $past(excReq.number, 2)))
    else $error("active exception offered again");
endmodule : irq_ctrl_checker

bind nested_irq_controller irq_ctrl_checker irq_ctrl_checker_inst (.sys_clk, .rst_n, .nmiReq, .excAck, .excReq,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ### core_model.sv
`timescale 1ns/10ps
module core_model (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset
  input irq_ctrl_pkg::exc_req_t excReq, // offer
  input wire logic holdRet, // stall returns
  output logic excAck, // take pulse
  output logic excReturn, // return pulse
  output logic [5:0] excReturnNum // returning number
);
  logic [5:0] stk [8];
  logic [3:0] sp;
  // take offers at once, return newest first
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      excAck <= 1'b0;
      excReturn <= 1'b0;
      excReturnNum <= 6'h00;
      sp <= 4'h0;
    end else begin
      excAck <= excReq.valid && !excAck && !excReturn;
      excReturn <= 1'b0;
      excReturnNum <= ~excReturnNum;
      if (excAck && excReq.valid) begin
        stk[sp[2:0]] <= excReq.number;
        sp <= sp + 4'h1;
      end else if (!holdRet && sp != 4'h0 && !excReturn && !excReq.valid) begin
        excReturn <= 1'b1;
        excReturnNum <= stk[sp[2:0] - 3'h1];
        sp <= sp - 4'h1;
      end
    end
  end
endmodule : core_model

// ### nested_irq_controller_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module nested_irq_controller_tb_top;
  logic sys_clk, rst_n, brownout_irq, watchdog_irq, ext_pin_irq_a, ext_pin_irq_b, nmiReq, hardFaultReq;
  logic system_timer_exc, supervisor_call_exc, holdRet, excAck, excReturn, wakeReq, irqOut;
  logic [31:0] periphIrq, s_axi_wdata, s_axi_rdata, rdat;
  logic [15:0] portLowPins;
  logic [23:0] portHighPins;
  logic [5:0] excReturnNum;
  irq_ctrl_pkg::exc_req_t excReq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int miscompares, nCompared, cycles;
  logic [5:0] q [$];
  logic [5:0] expQ [12] = '{6'h10, 6'h02, 6'h11, 6'h14, 6'h15, 6'h13, 6'h16, 6'h12, 6'h03, 6'h0B, 6'h0E, 6'h0F};

  nested_irq_controller nested_irq_controller_inst (.*);
  core_model core_model_inst (.*);

  // clock and hang limit
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finalReport();
    end
  end
  // log every taken exception
  always @(negedge sys_clk) begin
    if (excAck && excReq.valid) q.push_back(excReq.number);
  end

  task automatic finalReport;
    if (miscompares == 0 && nCompared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finalReport

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic awT, wT, done;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      awT = s_axi_awvalid && s_axi_awready;
      wT = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge sys_clk);
      if (awT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
    end while (!done);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    logic aT, done;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      aT = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge sys_clk);
      if (aT) s_axi_arvalid <= 1'b0;
    end while (!done);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rdat, e)
  endtask : rdChk

  task automatic waitQ(input int n);
    while (q.size() < n) @(posedge sys_clk);
  endtask : waitQ

  // main sequence
  initial begin
    {rst_n, brownout_irq, watchdog_irq, ext_pin_irq_a, ext_pin_irq_b, nmiReq, hardFaultReq} = 7'h00;
    {system_timer_exc, supervisor_call_exc, holdRet, periphIrq, portLowPins, portHighPins} = 75'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdChk(12'h400 + 12'(4 * i), 32'h0);
    rdChk(12'h100, 32'h0);
    rdChk(12'h504, 32'h0);
    wr(12'h400, 32'hFFFFFFFF);
    rdChk(12'h400, 32'hC0C0C0C0);
    wr(12'h100, 32'h3);
    rdChk(12'h180, 32'h3);
    wr(12'h180, 32'h1);
    wr(12'h100, 32'h0);
    rdChk(12'h100, 32'h2);
    // disabled line only pends
    brownout_irq <= 1'b1;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(excReq.valid, 1'b0)
    rdChk(12'h200, 32'h1);
    wr(12'h280, 32'h1);
    rdChk(12'h280, 32'h0);
    wr(12'h200, 32'h1);
    rdChk(12'h280, 32'h1);
    // taken line stays active while disabled and unpended
    holdRet <= 1'b1;
    wr(12'h100, 32'h1);
    waitQ(1);
    rdChk(12'h300, 32'h1);
    rdChk(12'h200, 32'h0);
    wr(12'h180, 32'h1);
    rdChk(12'h300, 32'h1);
    wr(12'h200, 32'h1);
    wr(12'h280, 32'h1);
    rdChk(12'h300, 32'h1);
    nmiReq <= 1'b1;
    waitQ(2);
    nmiReq <= 1'b0;
    holdRet <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rdChk(12'h300, 32'h0);
    // many lines at mixed levels
    holdRet <= 1'b1;
    wr(12'h400, 32'h40C00000);
    wr(12'h404, 32'h00800000);
    rdChk(12'h404, 32'h00800000);
    wr(12'h100, 32'h7E);
    watchdog_irq <= 1'b1;
    ext_pin_irq_a <= 1'b1;
    ext_pin_irq_b <= 1'b1;
    portLowPins <= 16'h0008;
    portHighPins <= 24'h000080;
    periphIrq <= 32'h00000040;
    waitQ(3);
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK(wakeReq, 1'b1)
    @(posedge sys_clk);
    holdRet <= 1'b0;
    waitQ(8);
    // system exceptions behind a hard fault
    holdRet <= 1'b1;
    hardFaultReq <= 1'b1;
    waitQ(9);
    hardFaultReq <= 1'b0;
    supervisor_call_exc <= 1'b1;
    system_timer_exc <= 1'b1;
    @(posedge sys_clk);
    supervisor_call_exc <= 1'b0;
    system_timer_exc <= 1'b0;
    wr(12'h508, 32'h2);
    holdRet <= 1'b0;
    waitQ(12);
    foreach (expQ[i]) `CHK(q[i], expQ[i])
    // event status and masked interrupt
    @(negedge sys_clk);
    `CHK(irqOut, 1'b0)
    wr(12'h504, 32'h3);
    @(negedge sys_clk);
    `CHK(irqOut, 1'b1)
    rd(12'h500);
    `CHK(rdat & 32'h3, 32'h3)
    @(negedge sys_clk);
    `CHK(irqOut, 1'b0)
    // upper line numbers map above 31
    wr(12'h100, 32'h00100000);
    holdRet <= 1'b1;
    periphIrq <= 32'h00100040;
    waitQ(13);
    `CHK(q[12], 6'h24)
    rdChk(12'h300, 32'h00100000);
    holdRet <= 1'b0;
    // unmapped place
    wr(12'h600, 32'h1);
    `CHK(resp, 2'h2)
    rdChk(12'h600, 32'h0);
    `CHK(resp, 2'h2)
    finalReport();
  end
endmodule : nested_irq_controller_tb_top
